//--- hw/irc_pkg.sv
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
`default_nettype none

package irc_pkg;

  //----------------------------------------------------------------------------
  // register indices; byte address on the bus is four times the index
  //----------------------------------------------------------------------------
  localparam logic [11:0] IRC_IDX_FLAGS_A = 12'hFC0;
  localparam logic [11:0] IRC_IDX_ENH_A   = 12'hFC1;
  localparam logic [11:0] IRC_IDX_ENL_A   = 12'hFC2;
  localparam logic [11:0] IRC_IDX_FLAGS_B = 12'hFC3;
  localparam logic [11:0] IRC_IDX_ENH_B   = 12'hFC4;
  localparam logic [11:0] IRC_IDX_ENL_B   = 12'hFC5;
  localparam logic [11:0] IRC_IDX_FLAGS_C = 12'hFC6;
  localparam logic [11:0] IRC_IDX_ENH_C   = 12'hFC7;
  localparam logic [11:0] IRC_IDX_ENL_C   = 12'hFC8;
  localparam logic [11:0] IRC_IDX_EDGE    = 12'hFCD;
  localparam logic [11:0] IRC_IDX_PORT    = 12'hFCE;
  localparam logic [11:0] IRC_IDX_CTL     = 12'hFCF;

  //----------------------------------------------------------------------------
  // field positions and reset values
  //----------------------------------------------------------------------------
  localparam int          IRC_CTL_GLOBAL_EN_BIT = 7;    // global request enable
  localparam int          IRC_C_PIN_LSB         = 0;    // port c pins 3:0
  localparam int          IRC_C_PERIPH_LSB      = 4;    // dma, tx1, rx1, timer3
  localparam logic [7:0]  IRC_REG_RST           = 8'h00;
  localparam logic [31:0] IRC_RDATA_RST         = 32'h0000_0000;
  localparam int          IRC_NUM_SRC           = 24;   // flat source count

  //----------------------------------------------------------------------------
  // carriers
  //----------------------------------------------------------------------------
  typedef struct packed {
    logic [4:0] src;                                    // flat source index
    logic [1:0] lvl;                                    // priority level
  } irc_pick_t;

  typedef struct packed {
    logic [19:0] s1;                                    // pin sync stage 1
    logic [19:0] s2;                                    // pin sync stage 2
    logic [19:0] s3;                                    // pin sync stage 3
    logic [19:0] filt;                                  // accepted pin levels
    logic [7:0]  flag_a;
    logic [7:0]  flag_b;
    logic [7:0]  flag_c;
    logic [7:0]  enh_a;
    logic [7:0]  enl_a;
    logic [7:0]  enh_b;
    logic [7:0]  enl_b;
    logic [7:0]  enh_c;
    logic [7:0]  enl_c;
    logic [7:0]  edge_sel;
    logic [7:0]  port_sel;
    logic [7:0]  ctl;
    logic        wait_r;                                // waitrequest flop
    logic [31:0] rdata;
    logic        irq;
    irc_pick_t   pick;
  } irc_state_t;

  localparam irc_state_t IRC_STATE_RST = '{wait_r: 1'h1, default: '0};

endpackage : irc_pkg

`default_nettype wire

//--- hw/irc_top.sv
// The implementer's own choice: the Avalon-MM slave port.
`default_nettype none

module irc_top
  import irc_pkg::*;
(
  input  wire logic        i_core_clk,         // system clock, 250 MHz
  input  wire logic        i_rst_b,            // synchronous reset, active low
  input  wire logic        i_clk_en,           // low freezes all state; reset still clears it
  input  wire logic [13:0] i_avs_address,      // byte address
  input  wire logic        i_avs_read,         // read request
  input  wire logic        i_avs_write,        // write request
  input  wire logic [3:0]  i_avs_byteenable,   // only lane 0 carries data
  input  wire logic [31:0] i_avs_writedata,    // write data
  output logic      [31:0] o_avs_readdata,     // read data
  output logic             o_avs_waitrequest,  // low marks the accepting edge
  input  wire logic [7:0]  i_periph_req,       // group a peripheral requests
  input  wire logic [3:0]  i_group_c_req,      // dma, tx1, rx1, timer3
  input  wire logic [7:0]  i_port_a_pins,      // asynchronous port a pins
  input  wire logic [7:0]  i_port_d_pins,      // asynchronous port d pins
  input  wire logic [3:0]  i_port_c_pins,      // asynchronous port c pins 3:0
  output logic             o_irq,              // level interrupt to the core
  output logic      [4:0]  o_irq_source,       // winning flat source index
  output logic      [1:0]  o_irq_level         // winning priority level
);

  //----------------------------------------------------------------------------
  // state
  //----------------------------------------------------------------------------
  irc_state_t st;
  irc_state_t nx;
  logic [19:0] stable;
  logic [19:0] rise;
  logic [19:0] fall;
  logic [7:0]  evt_b;
  logic [3:0]  evt_c;
  logic [7:0]  set_c;
  logic [23:0] flags;
  logic [23:0] en_hi;
  logic [23:0] en_lo;
  logic [23:0] pend;
  logic [11:0] idx;
  logic        wr_go;
  logic [7:0]  wd;

  // best pending source: higher level wins, lower index wins a tie
  function automatic irc_pick_t irc_pick(input logic [23:0] p,
                                         input logic [23:0] hi,
                                         input logic [23:0] lo);
    irc_pick_t r;
    r = '0;
    for (int k = 0; k < IRC_NUM_SRC; k++) begin
      if (p[k] && ({hi[k], lo[k]} > r.lvl)) begin
        r.lvl = {hi[k], lo[k]};
        r.src = 5'(k);
      end
    end
    return r;
  endfunction : irc_pick

  //----------------------------------------------------------------------------
  // pin edge detection
  //----------------------------------------------------------------------------
  // a pin change counts only once stages two and three agree
  assign stable = ~(st.s2 ^ st.s3);
  assign rise   = stable & st.s3 & ~st.filt;
  assign fall   = stable & ~st.s3 & st.filt;

  // edges are taken per port before the mux, so flipping the port select
  // never fabricates an edge out of two different pin levels
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin_b
      logic ev_a;
      logic ev_d;
      assign ev_a     = st.edge_sel[g] ? rise[g] : fall[g];
      assign ev_d     = st.edge_sel[g] ? rise[8 + g] : fall[8 + g];
      assign evt_b[g] = st.port_sel[g] ? ev_d : ev_a;
    end
    for (g = 0; g < 4; g++) begin : g_pin_c
      assign evt_c[g] = st.edge_sel[g] ? rise[16 + g] : fall[16 + g];
    end
  endgenerate

  assign set_c = {i_group_c_req, evt_c};

  //----------------------------------------------------------------------------
  // flat view of sources for the priority pick
  //----------------------------------------------------------------------------
  assign flags = {st.flag_c, st.flag_b, st.flag_a};
  assign en_hi = {st.enh_c, st.enh_b, st.enh_a};
  assign en_lo = {st.enl_c, st.enl_b, st.enl_a};
  assign pend  = flags & (en_hi | en_lo);

  // bus: the write lands on the edge where waitrequest is sampled low
  assign idx   = i_avs_address[13:2];
  assign wr_go = !st.wait_r && i_avs_write && i_avs_byteenable[0];
  assign wd    = i_avs_writedata[7:0];

  //----------------------------------------------------------------------------
  // next state
  //----------------------------------------------------------------------------
  always_comb begin
    logic [7:0] clr_a;
    logic [7:0] clr_b;
    logic [7:0] clr_c;
    logic [7:0] rd;
    nx    = st;
    clr_a = 8'h00;
    clr_b = 8'h00;
    clr_c = 8'h00;
    rd    = 8'h00;

    // three-stage synchroniser and filtered level
    nx.s1 = {i_port_c_pins, i_port_d_pins, i_port_a_pins};
    nx.s2 = st.s1;
    nx.s3 = st.s2;
    for (int k = 0; k < 20; k++) begin
      if (stable[k]) begin
        nx.filt[k] = st.s3[k];
      end
    end

    // register writes; flags clear by writing one
    if (wr_go) begin
      unique case (idx)
        IRC_IDX_FLAGS_A: clr_a       = wd;
        IRC_IDX_ENH_A:   nx.enh_a    = wd;
        IRC_IDX_ENL_A:   nx.enl_a    = wd;
        IRC_IDX_FLAGS_B: clr_b       = wd;
        IRC_IDX_ENH_B:   nx.enh_b    = wd;
        IRC_IDX_ENL_B:   nx.enl_b    = wd;
        IRC_IDX_FLAGS_C: clr_c       = wd;
        IRC_IDX_ENH_C:   nx.enh_c    = wd;
        IRC_IDX_ENL_C:   nx.enl_c    = wd;
        IRC_IDX_EDGE:    nx.edge_sel = wd;
        IRC_IDX_PORT:    nx.port_sel = wd;
        IRC_IDX_CTL:     nx.ctl      = wd & 8'h80;  // reserved bits stay zero
        default:         ;
      endcase
    end

    // a set in the clearing cycle wins, so no request is lost
    nx.flag_a = (st.flag_a & ~clr_a) | i_periph_req;
    nx.flag_b = (st.flag_b & ~clr_b) | evt_b;
    nx.flag_c = (st.flag_c & ~clr_c) | set_c;

    // read mux; unmapped indices read zero
    unique case (idx)
      IRC_IDX_FLAGS_A: rd = st.flag_a;
      IRC_IDX_ENH_A:   rd = st.enh_a;
      IRC_IDX_ENL_A:   rd = st.enl_a;
      IRC_IDX_FLAGS_B: rd = st.flag_b;
      IRC_IDX_ENH_B:   rd = st.enh_b;
      IRC_IDX_ENL_B:   rd = st.enl_b;
      IRC_IDX_FLAGS_C: rd = st.flag_c;
      IRC_IDX_ENH_C:   rd = st.enh_c;
      IRC_IDX_ENL_C:   rd = st.enl_c;
      IRC_IDX_EDGE:    rd = st.edge_sel;
      IRC_IDX_PORT:    rd = st.port_sel;
      IRC_IDX_CTL:     rd = st.ctl;
      default:         rd = 8'h00;
    endcase

    // one wait cycle per access, then a single accepting cycle
    if (!st.wait_r) begin
      nx.wait_r = 1'h1;
    end else if (i_avs_read || i_avs_write) begin
      nx.wait_r = 1'h0;
      nx.rdata  = i_avs_read ? {24'h00_0000, rd} : IRC_RDATA_RST;
    end

    // interrupt out, gated by the global enable
    nx.irq  = st.ctl[IRC_CTL_GLOBAL_EN_BIT] && (|pend);
    nx.pick = irc_pick(pend, en_hi, en_lo);
  end

  //----------------------------------------------------------------------------
  // state register
  //----------------------------------------------------------------------------
  // reset acts even with the clock enable low, so a frozen block still clears
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      st <= IRC_STATE_RST;
    end else if (i_clk_en) begin
      st <= nx;
    end
  end

  assign o_avs_readdata    = st.rdata;
  assign o_avs_waitrequest = st.wait_r;
  assign o_irq             = st.irq;
  assign o_irq_source      = st.pick.src;
  assign o_irq_level       = st.pick.lvl;

  //----------------------------------------------------------------------------
  // checks
  //----------------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);

  chk_periph_flag_set: assert property (
    i_clk_en && i_periph_req[0] |=> st.flag_a[0] && flags[0])
    else $error("group a request did not set its flag");

  chk_pin_b_flag: assert property (
    i_clk_en && st.edge_sel[3] && !st.port_sel[3] && rise[3] |=> st.flag_b[3])
    else $error("rising port a edge did not set pin flag");

  chk_pin_d_fall: assert property (
    i_clk_en && !st.edge_sel[2] && st.port_sel[2] && fall[10] |=> st.flag_b[2])
    else $error("falling port d edge did not set pin flag");

  chk_port_c_flag: assert property (
    i_clk_en && (rise[16] || fall[16]) && (st.edge_sel[0] == rise[16])
      |=> st.flag_c[0])
    else $error("port c edge did not set pin flag");

  chk_global_block: assert property (
    i_clk_en && !st.ctl[IRC_CTL_GLOBAL_EN_BIT] |=> !o_irq)
    else $error("interrupt raised with global enable clear");

  chk_irq_raise: assert property (
    i_clk_en && st.ctl[IRC_CTL_GLOBAL_EN_BIT] && (|pend) |=> o_irq)
    else $error("enabled pending request not signalled");

  chk_irq_level: assert property (
    o_irq |-> (o_irq_level != 2'h0) && ((($past(pend) >> o_irq_source) & 24'h00_0001) != 24'h0))
    else $error("signalled source not pending or level zero");

  chk_bus_accept: assert property (
    i_clk_en && st.wait_r && (i_avs_read || i_avs_write)
      |=> !o_avs_waitrequest ##1 o_avs_waitrequest || !i_clk_en)
    else $error("bus access not answered after one wait cycle");

endmodule : irc_top

`default_nettype wire

//--- testbench/irc_core_model.sv
`default_nettype none
// -----------------------------------------------
// core side of the request line
// -----------------------------------------------
module irc_core_model (
  input  wire logic       i_core_clk,  // system clock
  input  wire logic       i_rst_b,     // reset, active low
  input  wire logic       i_irq,       // level request
  input  wire logic [4:0] i_src,       // source index
  input  wire logic [1:0] i_lvl,       // priority level
  output logic      [6:0] o_taken      // {level, source} at last entry
);
  timeunit 1ns;
  timeprecision 1ps;
  logic irq_r;
  // a level line stays high for many cycles; only its rise is an entry
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      irq_r   <= 1'b0;
      o_taken <= 7'h00;
    end else begin
      irq_r <= i_irq;
      if (i_irq && !irq_r) begin
        o_taken <= {i_lvl, i_src};
      end
    end
  end
endmodule : irc_core_model
`default_nettype wire

//--- testbench/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        ce = 1'b1;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [3:0]  be = 4'h1;
  logic [13:0] addr = 14'h0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic        wait_req;
  logic        irq;
  logic [7:0]  preq = 8'h00;
  logic [7:0]  pa = 8'h00;
  logic [7:0]  pd = 8'hFF;
  logic [3:0]  creq = 4'h0;
  logic [3:0]  pc = 4'h0;
  logic [4:0]  src;
  logic [1:0]  lvl;
  logic [6:0]  taken;
  logic [7:0]  ev;
  int          err_total = 0;
  int          samples_checked = 0;
  int          regs[12] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 13, 14, 15};
  int          rw[8] = '{1, 2, 4, 5, 7, 8, 13, 14};
  // 250 MHz
  always #2 clk = ~clk;
  irc_top uut (.i_core_clk(clk), .i_rst_b(rst_b), .i_clk_en(ce), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_byteenable(be), .i_avs_writedata(wdata),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .i_periph_req(preq),
    .i_group_c_req(creq), .i_port_a_pins(pa), .i_port_d_pins(pd), .i_port_c_pins(pc),
    .o_irq(irq), .o_irq_source(src), .o_irq_level(lvl));
  irc_core_model core (.i_core_clk(clk), .i_rst_b(rst_b), .i_irq(irq), .i_src(src),
    .i_lvl(lvl), .o_taken(taken));
  // -----------------------------------------------
  // access and compare helpers
  // -----------------------------------------------
  function automatic logic [13:0] ra(input int k);
    return 14'h3F00 + 14'(k * 4);
  endfunction : ra
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  // request held until waitrequest is seen low; one idle edge after so no
  // strobe is driven twice in one time step
  task automatic bus(input logic w, input logic [13:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= {24'h000000, d};
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (wait_req === 1'b0) break;
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n == 20) begin
      err_total++;
      close_out();
    end
    @(posedge clk);
  endtask : bus
  task automatic wreg(input logic [13:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wreg
  task automatic rchk(input logic [13:0] a, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check($sformatf("reg %0h", a), q, {24'h000000, exp});
  endtask : rchk
  // pin flags arrive after the synchroniser, so poll a bounded number of reads
  task automatic wait_flag(input logic [13:0] a, input logic [7:0] exp);
    logic [31:0] q;
    for (int n = 0; n < 12; n++) begin
      bus(1'b0, a, 8'h00, q);
      if (q === {24'h000000, exp}) break;
    end
    check($sformatf("flag %0h", a), q, {24'h000000, exp});
    wreg(a, exp);
  endtask : wait_flag
  // -----------------------------------------------
  // main sequence
  // -----------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    foreach (regs[i]) rchk(ra(regs[i]), 8'h00);
    foreach (rw[i]) wreg(ra(rw[i]), 8'h5A + 8'(rw[i]));
    foreach (rw[i]) rchk(ra(rw[i]), 8'h5A + 8'(rw[i]));
    wreg(ra(15), 8'hFF);
    rchk(ra(15), 8'h80);
    wreg(14'h3F24, 8'hFF);
    rchk(14'h3F24, 8'h00);
    be <= 4'h0;
    wreg(ra(15), 8'h00);
    be <= 4'h1;
    rchk(ra(15), 8'h80);
    foreach (rw[i]) wreg(ra(rw[i]), 8'h00);
    // a request seen while the clock enable is low must leave the flags frozen
    ce <= 1'b0;
    preq <= 8'h01;
    @(posedge clk);
    preq <= 8'h00;
    ce <= 1'b1;
    rchk(ra(0), 8'h00);
    // every peripheral source sets its own flag; pair 00 keeps the line quiet
    for (int j = 0; j < 12; j++) begin
      ev = (j < 8) ? 8'h01 << j : 8'h10 << (j - 8);
      if (j < 8) preq <= ev;
      else creq <= ev[7:4];
      @(posedge clk);
      preq <= 8'h00;
      creq <= 4'h0;
      rchk(ra((j < 8) ? 0 : 6), ev);
      check("irq off", irq, 0);
      wreg(ra((j < 8) ? 0 : 6), ev);
      rchk(ra((j < 8) ? 0 : 6), 8'h00);
    end
    // bit 0 at level 3 beats bit 7 at level 1
    wreg(ra(1), 8'h01);
    wreg(ra(2), 8'h81);
    preq <= 8'h81;
    @(posedge clk);
    preq <= 8'h00;
    repeat (3) @(posedge clk);
    check("irq", irq, 1);
    check("source", src, 0);
    check("level", lvl, 3);
    check("core entry", taken, 7'h60);
    wreg(ra(0), 8'h01);
    repeat (3) @(posedge clk);
    check("source", src, 7);
    check("level", lvl, 1);
    wreg(ra(15), 8'h00);
    repeat (3) @(posedge clk);
    check("irq gated", irq, 0);
    wreg(ra(0), 8'h80);
    // pin 2 rising from port a, pin 1 falling from port d
    wreg(ra(13), 8'h04);
    wreg(ra(14), 8'h02);
    pa <= 8'h04;
    wait_flag(ra(3), 8'h04);
    pa <= 8'h00;
    pd <= 8'hFD;
    wait_flag(ra(3), 8'h02);
    pc <= 4'h4;
    wait_flag(ra(6), 8'h04);
    close_out();
  end
endmodule : testbench
`default_nettype wire
